// ===== inc/mtsc_consts.svh
// Constants of the Manchester / Three-out-of-Six codec.
// Assumes byte-wide special function registers on paged addresses.
`ifndef MTSC_CONSTS_SVH
`define MTSC_CONSTS_SVH

// ----------------------------------------------------------------
// Register page and addresses
// ----------------------------------------------------------------
`define MTSC_PAGE 8'h02
`define MTSC_ADDR_DATA_LOW 8'hc2
`define MTSC_ADDR_DATA_MIDDLE 8'hc3
`define MTSC_ADDR_DATA_HIGH 8'hc4
`define MTSC_ADDR_CONTROL 8'hc5

// ----------------------------------------------------------------
// Control register fields and reset values
// ----------------------------------------------------------------
`define MTSC_CTL_READY 7
`define MTSC_CTL_ERROR 6
`define MTSC_CTL_FWD 5
`define MTSC_CTL_REV 4
`define MTSC_CTL_RSV 3
`define MTSC_CTL_DMA 2
`define MTSC_CTL_ENDIAN 1
`define MTSC_CTL_MODE 0
`define MTSC_CTL_RESET 8'h00
`define MTSC_DATA_RESET 8'h00

`endif

// ===== inc/mtsc_pkg.sv
// Types shared by the codec and its surroundings.
// Assumes the constants header is included by the design files.
package mtsc_pkg;

   // ----------------------------------------------------------------
   // Bus carriers
   // ----------------------------------------------------------------
   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] page;
      logic [7:0] addr;
      logic [7:0] wdata;
   } mtsc_sfr_req_t;

   typedef struct packed {
      logic valid;
      logic [7:0] data;
   } mtsc_byte_t;

   // ----------------------------------------------------------------
   // Sequencer states
   // ----------------------------------------------------------------
   typedef enum logic [3:0] {
      MTSC_IDLE = 4'b0001,
      MTSC_GATHER = 4'b0010,
      MTSC_CONVERT = 4'b0100,
      MTSC_EMIT = 4'b1000
   } mtsc_state_t;

endpackage : mtsc_pkg

// ===== hdl/mtsc_codec.sv
// Manchester and Three-out-of-Six byte codec with register and DMA paths.
// Assumes synchronous register strobes and byte streams on CLK.
`timescale 1ns/1ps
`include "mtsc_consts.svh"

// Operation
// - Reverse bit starts decode of data registers
// - Ready flag set when result is stored
// - Error flag on invalid six-bit group
// - Decode three bytes, result in data registers
// - Encode then decode returns original two bytes
// - Nibble 1111 maps to code 101001
// - Nibbles 0111-1110 use their fixed code words
// - Decode values 0x10 Manchester, 0x11 3of6
// - Encode values 0x20 Manchester, 0x21 3of6
// - Control write clears ready and error
// - Registers decode only on page 0x2
// - Decode error can raise an interrupt
// - DMA decode continues; error stays sticky
// - DMA decode values 0x16 and 0x17
// - DMA encode values 0x26, 0x27, error flag zero, ready set per group
// - Control at 0xC5, bit 3 reads zero
module mtsc_codec
   import mtsc_pkg::*;
(
   input wire logic CLK,
   input wire logic RESET,
   input wire mtsc_sfr_req_t SFR_REQ,
   output logic [7:0] SFR_RDATA,
   input wire mtsc_byte_t DMA_IN,
   output logic DMA_IN_READY,
   output mtsc_byte_t DMA_OUT,
   input wire logic DMA_OUT_READY,
   output logic ERR_IRQ
);

   // ----------------------------------------------------------------
   // Code tables
   // ----------------------------------------------------------------
   function automatic logic [5:0] mtsc_enc36(input logic [3:0] n);
      case (n)
         4'h0: mtsc_enc36 = 6'b010110;
         4'h1: mtsc_enc36 = 6'b001101;
         4'h2: mtsc_enc36 = 6'b001110;
         4'h3: mtsc_enc36 = 6'b001011;
         4'h4: mtsc_enc36 = 6'b011100;
         4'h5: mtsc_enc36 = 6'b011001;
         4'h6: mtsc_enc36 = 6'b011010;
         4'h7: mtsc_enc36 = 6'b010011;
         4'h8: mtsc_enc36 = 6'b101100;
         4'h9: mtsc_enc36 = 6'b100101;
         4'ha: mtsc_enc36 = 6'b100110;
         4'hb: mtsc_enc36 = 6'b100011;
         4'hc: mtsc_enc36 = 6'b110100;
         4'hd: mtsc_enc36 = 6'b110001;
         4'he: mtsc_enc36 = 6'b110010;
         default: mtsc_enc36 = 6'b101001;
      endcase
   endfunction : mtsc_enc36

   // Returns {valid, nibble}; searches the same table so both agree
   function automatic logic [4:0] mtsc_dec36(input logic [5:0] c);
      logic [4:0] r;
      r = 5'h00;
      for (int k = 0; k < 16; k++) begin
         if (mtsc_enc36(4'(k)) == c) begin
            r = {1'b1, 4'(k)};
         end
      end
      mtsc_dec36 = r;
   endfunction : mtsc_dec36

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   mtsc_state_t state_q;
   logic [7:0] ctl_q;
   logic [7:0] data_q [3];
   logic [1:0] cnt_q;
   logic [7:0] rdata_q;
   logic in_ready_q;
   mtsc_byte_t out_q;
   logic irq_q;

   logic hit;
   logic ctl_wr;
   logic start;
   logic is_36;
   logic is_dec;
   logic big_end;
   logic [1:0] need_in;
   logic [1:0] need_out;
   logic [23:0] raw;
   logic [23:0] code_e;
   logic [15:0] nib_d;
   logic [3:0] bad36;
   logic [15:0] man_e;
   logic [7:0] man_d;
   logic [7:0] badm;
   logic [23:0] result;
   logic dec_err;
   logic in_take;
   logic out_take;

   // Register decode only on the codec page
   assign hit = SFR_REQ.page == `MTSC_PAGE;
   assign ctl_wr = hit && SFR_REQ.wr && SFR_REQ.addr == `MTSC_ADDR_CONTROL;
   assign start = ctl_wr
      && (SFR_REQ.wdata[`MTSC_CTL_FWD] || SFR_REQ.wdata[`MTSC_CTL_REV]);
   assign is_36 = ctl_q[`MTSC_CTL_MODE];
   assign is_dec = ctl_q[`MTSC_CTL_REV];
   assign big_end = ctl_q[`MTSC_CTL_ENDIAN];
   assign raw = {data_q[2], data_q[1], data_q[0]};

   // Bytes consumed and produced per group in DMA mode
   assign need_in = is_dec ? (is_36 ? 2'd3 : 2'd2) : (is_36 ? 2'd2 : 2'd1);
   assign need_out = is_36 ? (is_dec ? 2'd2 : 2'd3) : (is_dec ? 2'd1 : 2'd2);

   // ----------------------------------------------------------------
   // Per-nibble and per-bit coders
   // ----------------------------------------------------------------
   for (genvar i = 0; i < 8; i++) begin : g_bit
      if (i < 4) begin : g_nib
         logic [4:0] d;
         assign code_e[6*i +: 6] = mtsc_enc36(raw[4*i +: 4]);
         assign d = mtsc_dec36(raw[6*i +: 6]);
         assign nib_d[4*i +: 4] = d[3:0];
         assign bad36[i] = ~d[4];
      end
      assign man_e[2*i +: 2] = {raw[i], ~raw[i]};
      assign man_d[i] = raw[2*i+1];
      assign badm[i] = raw[2*i+1] == raw[2*i];
   end

   // Select the result of the requested operation
   always_comb begin
      case ({is_36, is_dec})
         2'b11: result = {8'h00, nib_d};
         2'b10: result = code_e;
         2'b01: result = {16'h0000, man_d};
         default: result = {8'h00, man_e};
      endcase
   end
   assign dec_err = is_dec && (is_36 ? |bad36 : |badm);
   assign in_take = DMA_IN.valid && in_ready_q;
   assign out_take = out_q.valid && DMA_OUT_READY;

   // ----------------------------------------------------------------
   // Sequencer
   // ----------------------------------------------------------------
   // A control write restarts, or stops to idle without FWD or REV; DMA groups loop until rewritten
   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET) begin
         state_q <= MTSC_IDLE;
         cnt_q <= 2'd0;
      end else if (ctl_wr) begin
         cnt_q <= 2'd0;
         if (!start) begin
            state_q <= MTSC_IDLE;
         end else if (SFR_REQ.wdata[`MTSC_CTL_DMA]) begin
            state_q <= MTSC_GATHER;
         end else begin
            state_q <= MTSC_CONVERT;
         end
      end else begin
         case (state_q)
            MTSC_GATHER: begin
               if (in_take) begin
                  if (cnt_q == need_in - 2'd1) begin
                     cnt_q <= 2'd0;
                     state_q <= MTSC_CONVERT;
                  end else begin
                     cnt_q <= cnt_q + 2'd1;
                  end
               end
            end
            MTSC_CONVERT: begin
               cnt_q <= 2'd0;
               state_q <= ctl_q[`MTSC_CTL_DMA] ? MTSC_EMIT : MTSC_IDLE;
            end
            MTSC_EMIT: begin
               if (out_take) begin
                  if (cnt_q == need_out - 2'd1) begin
                     cnt_q <= 2'd0;
                     state_q <= MTSC_GATHER;
                  end else begin
                     cnt_q <= cnt_q + 2'd1;
                  end
               end
            end
            default: state_q <= state_q;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Control register
   // ----------------------------------------------------------------
   // Hardware setting a flag wins over a clearing write
   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET) begin
         ctl_q <= `MTSC_CTL_RESET;
      end else begin
         if (ctl_wr) begin
            ctl_q[5:4] <= SFR_REQ.wdata[5:4];
            ctl_q[2:0] <= SFR_REQ.wdata[2:0];
         end
         if (state_q == MTSC_CONVERT) begin
            ctl_q[`MTSC_CTL_READY] <= 1'b1;
            if (dec_err) begin
               ctl_q[`MTSC_CTL_ERROR] <= 1'b1;
            end else if (ctl_wr) begin
               ctl_q[`MTSC_CTL_ERROR] <= 1'b0;
            end
         end else if (ctl_wr) begin
            ctl_q[`MTSC_CTL_READY] <= 1'b0;
            ctl_q[`MTSC_CTL_ERROR] <= 1'b0;
         end
         ctl_q[`MTSC_CTL_RSV] <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Data registers
   // ----------------------------------------------------------------
   // Conversion and DMA bytes take priority over software writes
   for (genvar b = 0; b < 3; b++) begin : g_data
      always_ff @(posedge CLK or posedge RESET) begin
         if (RESET) begin
            data_q[b] <= `MTSC_DATA_RESET;
         end else if (state_q == MTSC_CONVERT) begin
            data_q[b] <= result[8*b +: 8];
         end else if (state_q == MTSC_GATHER && in_take) begin
            if (big_end) begin
               data_q[b] <= (b == 0) ? DMA_IN.data
                  : data_q[(b > 0) ? b - 1 : 0];
            end else if (cnt_q == 2'(b)) begin
               data_q[b] <= DMA_IN.data;
            end
         end else if (hit && SFR_REQ.wr
            && SFR_REQ.addr == 8'(`MTSC_ADDR_DATA_LOW + b)) begin
            data_q[b] <= SFR_REQ.wdata;
         end
      end
   end

   // ----------------------------------------------------------------
   // Register read port
   // ----------------------------------------------------------------
   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET) begin
         rdata_q <= 8'h00;
      end else if (hit && SFR_REQ.rd) begin
         case (SFR_REQ.addr)
            `MTSC_ADDR_DATA_LOW: rdata_q <= data_q[0];
            `MTSC_ADDR_DATA_MIDDLE: rdata_q <= data_q[1];
            `MTSC_ADDR_DATA_HIGH: rdata_q <= data_q[2];
            `MTSC_ADDR_CONTROL: rdata_q <= ctl_q;
            default: rdata_q <= 8'h00;
         endcase
      end else begin
         rdata_q <= 8'h00;
      end
   end

   // ----------------------------------------------------------------
   // DMA byte streams
   // ----------------------------------------------------------------
   // Input ready while gathering, dropped after the group's last byte
   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET) begin
         in_ready_q <= 1'b0;
      end else if (ctl_wr) begin
         in_ready_q <= start && SFR_REQ.wdata[`MTSC_CTL_DMA];
      end else if (in_take && cnt_q == need_in - 2'd1) begin
         in_ready_q <= 1'b0;
      end else if (out_take && cnt_q == need_out - 2'd1) begin
         in_ready_q <= 1'b1;
      end
   end

   // Output bytes in the chosen order, high first when big-endian
   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET) begin
         out_q <= '0;
      end else if (ctl_wr) begin
         out_q <= '0;
      end else if (state_q == MTSC_CONVERT && ctl_q[`MTSC_CTL_DMA]) begin
         out_q.valid <= 1'b1;
         out_q.data <= big_end ? result[8*(need_out-2'd1) +: 8]
            : result[7:0];
      end else if (out_take) begin
         if (cnt_q == need_out - 2'd1) begin
            out_q.valid <= 1'b0;
         end else begin
            out_q.data <= big_end ? data_q[need_out - cnt_q - 2'd2]
               : data_q[cnt_q + 2'd1];
         end
      end
   end

   // Error interrupt request follows the sticky error flag
   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET) begin
         irq_q <= 1'b0;
      end else begin
         irq_q <= ctl_q[`MTSC_CTL_ERROR];
      end
   end

   assign SFR_RDATA = rdata_q;
   assign DMA_IN_READY = in_ready_q;
   assign DMA_OUT = out_q;
   assign ERR_IRQ = irq_q;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge CLK); endclocking
   default disable iff (RESET);

   reg_start_a: assert property (
      start && !SFR_REQ.wdata[`MTSC_CTL_DMA]
      |=> state_q == MTSC_CONVERT ##1 ctl_q[`MTSC_CTL_READY])
      else $error("register start did not convert");
   ready_set_a: assert property (
      state_q == MTSC_CONVERT |=> ctl_q[`MTSC_CTL_READY])
      else $error("ready not set after conversion");
   bad_group_a: assert property (
      state_q == MTSC_CONVERT && is_dec && is_36 && |bad36
      |=> ctl_q[`MTSC_CTL_ERROR] ##1 ERR_IRQ)
      else $error("invalid group not flagged");
   code_f_a: assert property (
      state_q == MTSC_CONVERT && is_36 && !is_dec && raw[3:0] == 4'hf
      |=> data_q[0][5:0] == 6'b101001)
      else $error("nibble f coded wrongly");
   code_d_a: assert property (
      state_q == MTSC_CONVERT && is_36 && !is_dec && raw[7:4] == 4'hd
      |=> {data_q[1][3:0], data_q[0][7:6]} == 6'b110001)
      else $error("nibble d coded wrongly");
   flag_clear_a: assert property (
      ctl_wr && state_q != MTSC_CONVERT
      |=> !ctl_q[`MTSC_CTL_READY] && !ctl_q[`MTSC_CTL_ERROR])
      else $error("control write left flags set");
   page_gate_a: assert property (
      SFR_REQ.wr && SFR_REQ.page != `MTSC_PAGE
      && state_q == MTSC_IDLE |=> $stable(ctl_q) && $stable(data_q[0]))
      else $error("write taken off page");
   error_sticky_a: assert property (
      ctl_q[`MTSC_CTL_ERROR] && !ctl_wr |=> ctl_q[`MTSC_CTL_ERROR])
      else $error("error flag lost during transfer");
   rsv_zero_a: assert property (
      hit && SFR_REQ.rd && SFR_REQ.addr == `MTSC_ADDR_CONTROL
      |=> !SFR_RDATA[`MTSC_CTL_RSV])
      else $error("reserved control bit read one");

endmodule : mtsc_codec

// ===== verification/mtsc_dma_model.sv
// Byte-stream partner of the codec: an input and an output DMA channel.
// Assumes the bench fills in_q and reads out_q between clock edges.
`timescale 1ns/1ps
module mtsc_dma_model
   import mtsc_pkg::*;
(
   input wire logic clk,
   input wire logic reset,
   output mtsc_byte_t in_byte,
   input wire logic in_ready,
   input wire mtsc_byte_t out_byte,
   output logic out_ready
);
   // ----------------------------------------------------------------
   // Queues and pacing
   // ----------------------------------------------------------------
   logic [7:0] in_q[$];
   logic [7:0] out_q[$];
   logic slow = 1'b0;
   // Stall: both channels hold off, as an abort handler does
   logic stall = 1'b0;

   // Input channel: feeds memory bytes in order, holds each until taken
   always @(posedge clk or posedge reset) begin
      if (reset) begin
         in_byte <= '0;
      end else begin
         if (in_byte.valid && in_ready) begin
            void'(in_q.pop_front());
         end
         if (in_q.size() > 0 && !stall) begin
            in_byte.valid <= 1'b1;
            in_byte.data <= in_q[0];
         end else begin
            // Released data line shows a changing pattern
            in_byte.valid <= 1'b0;
            in_byte.data <= ~in_byte.data;
         end
      end
   end

   // Output channel: stores taken bytes, stalls every other cycle if slow
   always @(posedge clk or posedge reset) begin
      if (reset) begin
         out_ready <= 1'b0;
      end else begin
         if (out_byte.valid && out_ready) begin
            out_q.push_back(out_byte.data);
         end
         out_ready <= stall ? 1'b0 : slow ? ~out_ready : 1'b1;
      end
   end
endmodule : mtsc_dma_model

// ===== verification/tb_top.sv
// Self-checking bench of the codec: register and DMA operations.
// Assumes the codec, its package and the DMA partner model.
`timescale 1ns/1ps
`include "mtsc_consts.svh"
module tb_top
   import mtsc_pkg::*;
;
   // ----------------------------------------------------------------
   // Signals and instances
   // ----------------------------------------------------------------
   logic clk = 1'b0;
   logic reset = 1'b1;
   mtsc_sfr_req_t req = '0;
   logic [7:0] rdata;
   mtsc_byte_t in_byte;
   mtsc_byte_t out_byte;
   logic in_ready;
   logic out_ready;
   logic irq;
   int miscompares = 0;
   int n_checks = 0;
   // Three-out-of-Six code words by nibble
   logic [5:0] cw [16] = '{6'h16, 6'h0d, 6'h0e, 6'h0b, 6'h1c, 6'h19,
      6'h1a, 6'h13, 6'h2c, 6'h25, 6'h26, 6'h23, 6'h34, 6'h31, 6'h32,
      6'h29};

   mtsc_codec dut (.CLK(clk), .RESET(reset), .SFR_REQ(req),
      .SFR_RDATA(rdata), .DMA_IN(in_byte), .DMA_IN_READY(in_ready),
      .DMA_OUT(out_byte), .DMA_OUT_READY(out_ready), .ERR_IRQ(irq));
   mtsc_dma_model dma (.clk(clk), .reset(reset), .in_byte(in_byte),
      .in_ready(in_ready), .out_byte(out_byte), .out_ready(out_ready));

   // 10 MHz clock
   initial begin
      forever #50 clk = ~clk;
   end

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   function automatic logic [23:0] enc36(input logic [15:0] v);
      logic [23:0] r;
      r = '0;
      for (int i = 0; i < 4; i++) r[6*i +: 6] = cw[v[4*i +: 4]];
      return r;
   endfunction : enc36

   function automatic logic [15:0] man(input logic [7:0] d);
      logic [15:0] r;
      for (int j = 0; j < 8; j++) r[2*j +: 2] = {d[j], ~d[j]};
      return r;
   endfunction : man

   task automatic chk(input logic [23:0] got, input logic [23:0] exp);
      n_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("unexpected at %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk

   task automatic wr(input logic [7:0] pg, input logic [7:0] a,
      input logic [7:0] d);
      @(posedge clk);
      req <= '{wr: 1'b1, rd: 1'b0, page: pg, addr: a, wdata: d};
      @(posedge clk);
      req <= '0;
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk);
      req <= '{wr: 1'b0, rd: 1'b1, page: 8'h02, addr: a, wdata: 8'h00};
      @(posedge clk);
      req <= '0;
      @(negedge clk);
      d = rdata;
   endtask : rd

   // Clear, load, start, poll ready, read back all three bytes
   task automatic run_op(input logic [23:0] v, input logic [7:0] op,
      output logic [23:0] res, output logic [7:0] ctl);
      wr(8'h02, 8'hc5, 8'h00);
      wr(8'h02, 8'hc4, v[23:16]);
      wr(8'h02, 8'hc3, v[15:8]);
      wr(8'h02, 8'hc2, v[7:0]);
      wr(8'h02, 8'hc5, op);
      ctl = 8'h00;
      for (int i = 0; i < 20 && ctl[7] !== 1'b1; i++) rd(8'hc5, ctl);
      rd(8'hc4, res[23:16]);
      rd(8'hc3, res[15:8]);
      rd(8'hc2, res[7:0]);
   endtask : run_op

   task automatic complete_run;
      $display("checks %0d miscompares %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : complete_run

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic t_regs;
      logic [7:0] d;
      for (int a = 8'hc2; a <= 8'hc6; a++) begin
         rd(8'(a), d);
         chk(d, 8'h00);
      end
      wr(8'h01, 8'hc2, 8'h5a);
      rd(8'hc2, d);
      chk(d, 8'h00);
      wr(8'h02, 8'hc3, 8'h5a);
      rd(8'hc3, d);
      chk(d, 8'h5a);
      wr(8'h02, 8'hc5, 8'hc8);
      rd(8'hc5, d);
      chk(d, 8'h00);
      $display("test registers done");
   endtask : t_regs

   task automatic t_36;
      logic [23:0] r;
      logic [7:0] c;
      logic [15:0] v;
      for (int k = 0; k < 4; k++) begin
         v = {4'(4*k+3), 4'(4*k+2), 4'(4*k+1), 4'(4*k)};
         run_op({8'h00, v}, 8'h21, r, c);
         chk(r, enc36(v));
         chk(c, 8'ha1);
         run_op(r, 8'h11, r, c);
         chk(r, {8'h00, v});
         chk(c, 8'h91);
      end
      run_op(24'h00ffff, 8'h21, r, c);
      chk(r, {4{6'b101001}});
      run_op(24'hffffff, 8'h11, r, c);
      chk(c[6], 1'b1);
      @(negedge clk);
      chk(irq, 1'b1);
      wr(8'h02, 8'hc5, 8'h00);
      rd(8'hc5, c);
      chk(c, 8'h00);
      chk(irq, 1'b0);
      $display("test three of six done");
   endtask : t_36

   task automatic t_man;
      logic [23:0] r;
      logic [7:0] c;
      run_op(24'h0000a5, 8'h20, r, c);
      chk(r, {8'h00, man(8'ha5)});
      run_op(r, 8'h10, r, c);
      chk(r, 24'h0000a5);
      chk(c, 8'h90);
      run_op(24'h000000, 8'h10, r, c);
      chk(c[6], 1'b1);
      $display("test manchester done");
   endtask : t_man

   // Clear first so no stale group swallows the new input bytes
   task automatic dma_op(input logic [7:0] op, input logic [47:0] src,
      input int n_in, input int n_out);
      wr(8'h02, 8'hc5, 8'h00);
      @(negedge clk);
      dma.out_q.delete();
      for (int i = n_in - 1; i >= 0; i--) dma.in_q.push_back(src[8*i +: 8]);
      wr(8'h02, 8'hc5, op);
      for (int i = 0; i < 300 && dma.out_q.size() < n_out; i++) begin
         @(posedge clk);
      end
      @(negedge clk);
      chk(24'(dma.out_q.size()), 24'(n_out));
   endtask : dma_op

   task automatic t_dma;
      logic [23:0] e;
      logic [7:0] c;
      e = enc36(16'h1234);
      @(negedge clk);
      dma.slow = 1'b1;
      // Bad group first: decoding goes on and the error sticks
      dma_op(8'h17, {24'hffffff, e}, 6, 4);
      chk({dma.out_q[2], dma.out_q[3]}, 16'h1234);
      rd(8'hc5, c);
      chk(c[7:6], 2'b11);
      e = enc36(16'habcd);
      dma_op(8'h27, 48'habcd, 2, 3);
      chk({dma.out_q[0], dma.out_q[1], dma.out_q[2]}, e);
      dma_op(8'h25, 48'hcdab, 2, 3);
      chk({dma.out_q[2], dma.out_q[1], dma.out_q[0]}, e);
      dma_op(8'h26, 48'ha5, 1, 2);
      chk({dma.out_q[0], dma.out_q[1]}, man(8'ha5));
      dma_op(8'h16, 48'(man(8'ha5)), 2, 1);
      chk(dma.out_q[0], 8'ha5);
      $display("test dma done");
   endtask : t_dma

   // Abort at the first decode error: stall, disable, then clear
   task automatic t_abort;
      int n;
      logic [7:0] c;
      wr(8'h02, 8'hc5, 8'h00);
      @(negedge clk);
      dma.in_q = '{8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff};
      wr(8'h02, 8'hc5, 8'h17);
      for (int i = 0; i < 50 && irq !== 1'b1; i++) @(posedge clk);
      @(negedge clk);
      chk(irq, 1'b1);
      dma.stall = 1'b1;
      @(negedge clk);
      dma.in_q.delete();
      n = dma.out_q.size();
      repeat (20) @(posedge clk);
      @(negedge clk);
      chk(24'(dma.out_q.size()), 24'(n));
      wr(8'h02, 8'hc5, 8'h00);
      dma.stall = 1'b0;
      rd(8'hc5, c);
      chk({in_ready, irq, c}, 10'h000);
      $display("test abort done");
   endtask : t_abort

   // Main sequence: reset for 10 cycles, then the scenarios
   initial begin
      repeat (10) @(posedge clk);
      reset <= 1'b0;
      t_regs();
      t_36();
      t_man();
      t_dma();
      t_abort();
      complete_run();
   end

   // Watchdog cuts a hang short
   initial begin
      repeat (20000) @(posedge clk);
      miscompares++;
      complete_run();
   end
endmodule : tb_top
